// file: shared/gfe_pkg.sv
/*
 * gfe_pkg: constants, register map and carrier types for the gpi and
 * fan error status bank.
 * Assumes an APB master with 32-bit data and byte addressing.
 */
package gfe_pkg;

    localparam int unsigned GPI_N  = 8;
    localparam int unsigned FAN_N  = 4;
    localparam int unsigned FLAG_N = GPI_N + FAN_N;
    localparam int unsigned TACH_W = 16;
    localparam int unsigned ADDR_W = 12;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_GPI_FLAGS = 8'h46;
    localparam logic [7:0] IDX_FAN_FLAGS = 8'h47;
    localparam logic [7:0] IDX_GPI_MASK  = 8'h60;
    localparam logic [7:0] IDX_SLP_STATE = 8'h61;
    localparam logic [7:0] IDX_SLP_M_S1  = 8'h62;
    localparam logic [7:0] IDX_SLP_M_S3  = 8'h63;
    localparam logic [7:0] IDX_SLP_M_S45 = 8'h64;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h65;
    localparam logic [7:0] IDX_TACH_LIM0 = 8'h68;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [GPI_N-1:0]  RST_GPI_FLAGS = 8'h00;
    localparam logic [FAN_N-1:0]  RST_FAN_FLAGS = 4'h0;
    localparam logic [GPI_N-1:0]  RST_GPI_MASK  = 8'h00;
    localparam logic [FLAG_N-1:0] RST_SLP_MASK  = 12'h000;
    localparam logic [FLAG_N-1:0] RST_IRQ_MASK  = 12'h000;
    localparam logic [TACH_W-1:0] RST_TACH_LIM  = 16'hffff;

    ////////////////////////////////////////////////////////////////////////
    // sleep masking per state; layout {fan[3:0], gpi[7:0]}
    localparam logic [FLAG_N-1:0] OPT_S1  = 12'hfff;
    localparam logic [FLAG_N-1:0] OPT_S3  = 12'hfff;
    localparam logic [FLAG_N-1:0] OPT_S45 = 12'h021;
    localparam logic [FLAG_N-1:0] FIX_S45 = 12'hfde;

    typedef enum logic [1:0] {
        GFE_S0  = 2'h0,
        GFE_S1  = 2'h1,
        GFE_S3  = 2'h2,
        GFE_S45 = 2'h3
    } gfe_sleep_t;

    localparam gfe_sleep_t RST_SLP_STATE = GFE_S0;

    typedef logic [FAN_N-1:0][TACH_W-1:0] gfe_tach_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } gfe_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } gfe_apb_rsp_t;

endpackage

// file: rtl/gfe_sync.sv
/*
 * gfe_sync: two-flop synchroniser for a vector of pin levels.
 * Assumes each bit is an independent slow level.
 */
`timescale 1ns/1ns
module gfe_sync
    import gfe_pkg::*;
#(
    parameter int unsigned W = 1
)(
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    // levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // pins idle high, so reset to high to avoid a false low event
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '1;
            sync_o <= '1;
        end
        else if (ce_i)
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// file: rtl/gfe_flag_reg.sv
/*
 * gfe_flag_reg: sticky write-one-to-clear flag vector.
 * Assumes event and suppress are from the same clock domain.
 */
`timescale 1ns/1ns
module gfe_flag_reg
    import gfe_pkg::*;
#(
    parameter int unsigned  N   = 8,
    parameter logic [N-1:0] RST = '0
)(
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    // events
    input  wire logic [N-1:0] event_i,
    input  wire logic [N-1:0] suppress_i,
    // software clear
    input  wire logic         clr_wr_i,
    input  wire logic [N-1:0] clr_data_i,
    output logic      [N-1:0] flags_o
);
    logic [N-1:0] set_v;
    logic [N-1:0] clr_v;

    assign set_v = event_i & ~suppress_i;
    assign clr_v = clr_wr_i ? clr_data_i : '0;

    // a set in the clearing cycle wins so no event is lost
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flags_o <= RST;
        else if (ce_i)
            flags_o <= (flags_o & ~clr_v) | set_v;
    end

    a_set_wins_clr: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        ce_i |=> ((flags_o & $past(set_v)) == $past(set_v)))
        else $error("flag event lost");

    a_clear_only_one: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        ce_i |=> ((~flags_o & $past(flags_o) & ~$past(clr_v)) == '0))
        else $error("flag dropped without a one written");

    a_clear_takes: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (ce_i && clr_wr_i && (clr_data_i & ~set_v) != '0)
        |=> ((flags_o & $past(clr_data_i & ~set_v)) == '0))
        else $error("written one did not clear flag");
endmodule

// file: rtl/gfe_top.sv
/*
 * gfe_top: gpi and fan error status bank with APB slave, input mask,
 * tach limits, sleep-state masking and one masked interrupt line.
 * Assumes tach counts come from same-clock logic; pins are asynchronous.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module gfe_top
    import gfe_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    // register bus
    input  wire gfe_apb_req_t      apb_req_i,
    output gfe_apb_rsp_t           apb_rsp_o,
    // monitored inputs
    input  wire logic [GPI_N-1:0]  gpi_pin_i,
    input  wire gfe_tach_t         tach_count_i,
    // interrupt
    output logic                   irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic [7:0]  idx;
    logic        setup;
    logic        access;
    logic        phase_q;
    logic        hit;
    logic        wr_en;
    logic [31:0] wdat;
    logic [31:0] rd_d;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    assign idx    = apb_req_i.paddr[9:2];
    assign setup  = apb_req_i.psel && !apb_req_i.penable;
    assign access = apb_req_i.psel && apb_req_i.penable && phase_q;
    assign wdat   = apb_req_i.pwdata;

    // only word-aligned hits in the low 1 KiB window are mapped
    always_comb
    begin
        hit = 1'b0;
        if (apb_req_i.paddr[1:0] == 2'h0
            && apb_req_i.paddr[ADDR_W-1:10] == '0)
        begin
            case (idx)
                IDX_GPI_FLAGS,
                IDX_FAN_FLAGS,
                IDX_GPI_MASK,
                IDX_SLP_STATE,
                IDX_SLP_M_S1,
                IDX_SLP_M_S3,
                IDX_SLP_M_S45,
                IDX_IRQ_MASK:  hit = 1'b1;
                default:       hit = (idx[7:2] == IDX_TACH_LIM0[7:2]);
            endcase
        end
    end

    assign wr_en = access && ce_i && apb_req_i.pwrite && !pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // software registers

    logic [GPI_N-1:0]  gpi_mask_q;
    gfe_sleep_t        slp_state_q;
    logic [FLAG_N-1:0] slp_m_s1_q;
    logic [FLAG_N-1:0] slp_m_s3_q;
    logic [FLAG_N-1:0] slp_m_s45_q;
    logic [FLAG_N-1:0] irq_mask_q;
    gfe_tach_t         tach_lim_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gpi_mask_q  <= RST_GPI_MASK;
            slp_state_q <= RST_SLP_STATE;
            slp_m_s1_q  <= RST_SLP_MASK;
            slp_m_s3_q  <= RST_SLP_MASK;
            slp_m_s45_q <= RST_SLP_MASK;
            irq_mask_q  <= RST_IRQ_MASK;
        end
        else if (wr_en)
        begin
            case (idx)
                IDX_GPI_MASK:  gpi_mask_q  <= wdat[GPI_N-1:0];
                IDX_SLP_STATE: slp_state_q <= gfe_sleep_t'(wdat[1:0]);
                IDX_SLP_M_S1:  slp_m_s1_q  <= wdat[FLAG_N-1:0];
                IDX_SLP_M_S3:  slp_m_s3_q  <= wdat[FLAG_N-1:0];
                IDX_SLP_M_S45: slp_m_s45_q <= wdat[FLAG_N-1:0];
                IDX_IRQ_MASK:  irq_mask_q  <= wdat[FLAG_N-1:0];
                default:       ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tach_lim_q <= {FAN_N{RST_TACH_LIM}};
        else if (wr_en && idx[7:2] == IDX_TACH_LIM0[7:2])
            tach_lim_q[idx[1:0]] <= wdat[TACH_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // events and suppression

    logic [GPI_N-1:0]  gpi_s;
    logic [GPI_N-1:0]  gpi_evt;
    logic [FAN_N-1:0]  fan_evt;
    logic [FLAG_N-1:0] slp_sup;
    logic [GPI_N-1:0]  gpi_sup;

    gfe_sync #(
        .W          (GPI_N)
    ) u_gpi_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .async_i    (gpi_pin_i),
        .sync_o     (gpi_s)
    );

    assign gpi_evt = ~gpi_s;
    assign gpi_sup = gpi_mask_q | slp_sup[GPI_N-1:0];

    // larger count means a slower fan
    always_comb
    begin
        for (int k = 0; k < FAN_N; k++)
            fan_evt[k] = tach_count_i[k] > tach_lim_q[k];
    end

    // starred states suppress only if selected; plain states always do
    always_comb
    begin
        case (slp_state_q)
            GFE_S0:  slp_sup = '0;
            GFE_S1:  slp_sup = OPT_S1 & slp_m_s1_q;
            GFE_S3:  slp_sup = OPT_S3 & slp_m_s3_q;
            GFE_S45: slp_sup = FIX_S45 | (OPT_S45 & slp_m_s45_q);
            default: slp_sup = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky flags

    logic [GPI_N-1:0] gpi_flags_q;
    logic [FAN_N-1:0] fan_flags_q;

    gfe_flag_reg #(
        .N          (GPI_N),
        .RST        (RST_GPI_FLAGS)
    ) u_gpi_flags (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .event_i    (gpi_evt),
        .suppress_i (gpi_sup),
        .clr_wr_i   (wr_en && idx == IDX_GPI_FLAGS),
        .clr_data_i (wdat[GPI_N-1:0]),
        .flags_o    (gpi_flags_q)
    );

    // reserved bits 31:4 are never written, so they cannot clear anything
    gfe_flag_reg #(
        .N          (FAN_N),
        .RST        (RST_FAN_FLAGS)
    ) u_fan_flags (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .event_i    (fan_evt),
        .suppress_i (slp_sup[FLAG_N-1:GPI_N]),
        .clr_wr_i   (wr_en && idx == IDX_FAN_FLAGS),
        .clr_data_i (wdat[FAN_N-1:0]),
        .flags_o    (fan_flags_q)
    );

    assign irq_o = |({fan_flags_q, gpi_flags_q} & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // read mux and response

    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (idx)
            IDX_GPI_FLAGS: rd_d[GPI_N-1:0]  = gpi_flags_q;
            IDX_FAN_FLAGS: rd_d[FAN_N-1:0]  = fan_flags_q;
            IDX_GPI_MASK:  rd_d[GPI_N-1:0]  = gpi_mask_q;
            IDX_SLP_STATE: rd_d[1:0]        = slp_state_q;
            IDX_SLP_M_S1:  rd_d[FLAG_N-1:0] = slp_m_s1_q;
            IDX_SLP_M_S3:  rd_d[FLAG_N-1:0] = slp_m_s3_q;
            IDX_SLP_M_S45: rd_d[FLAG_N-1:0] = slp_m_s45_q;
            IDX_IRQ_MASK:  rd_d[FLAG_N-1:0] = irq_mask_q;
            default:
            begin
                if (idx[7:2] == IDX_TACH_LIM0[7:2])
                    rd_d[TACH_W-1:0] = tach_lim_q[idx[1:0]];
            end
        endcase
        if (!hit)
            rd_d = 32'h0000_0000;
    end

    // read data sampled in setup so it comes from a flop in access;
    // a setup edge lost to a low enable is taken at the next live edge
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase_q   <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (apb_req_i.psel && !phase_q)
            begin
                phase_q   <= 1'b1;
                prdata_q  <= apb_req_i.pwrite ? 32'h0000_0000 : rd_d;
                pslverr_q <= !hit;
            end
            else if (access)
                phase_q <= 1'b0;
        end
    end

    assign apb_rsp_o.pready  = access && ce_i;
    assign apb_rsp_o.pslverr = access && ce_i && pslverr_q;
    assign apb_rsp_o.prdata  = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_gpi_low_sets: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (ce_i && (~gpi_s & ~gpi_sup) != '0)
        |=> ((gpi_flags_q & $past(~gpi_s & ~gpi_sup))
             == $past(~gpi_s & ~gpi_sup)))
        else $error("low input pin did not set its flag");

    a_gpi_mask_holds: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        ce_i |=> ((gpi_flags_q & ~$past(gpi_flags_q)
                   & $past(gpi_mask_q)) == '0))
        else $error("masked input pin set its flag");

    a_fan_slow_sets: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (ce_i && (fan_evt & ~slp_sup[FLAG_N-1:GPI_N]) != '0)
        |=> ((fan_flags_q & $past(fan_evt & ~slp_sup[FLAG_N-1:GPI_N]))
             == $past(fan_evt & ~slp_sup[FLAG_N-1:GPI_N])))
        else $error("slow fan did not set its flag");

    a_fan_rsvd_zero: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (apb_rsp_o.pready && !apb_req_i.pwrite
         && idx == IDX_FAN_FLAGS)
        |-> (apb_rsp_o.prdata[31:FAN_N] == '0))
        else $error("fan reserved bits read nonzero");

    a_sleep_blocks: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        ce_i |=> (({fan_flags_q, gpi_flags_q}
                   & ~$past({fan_flags_q, gpi_flags_q})
                   & $past(slp_sup)) == '0))
        else $error("flag set in a suppressed sleep state");

    a_sleep_s0_open: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (slp_state_q == GFE_S0) |-> (slp_sup == '0))
        else $error("sleep masking active in working state");

    a_w1c_gpi: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (wr_en && idx == IDX_GPI_FLAGS && wdat[GPI_N-1:0] == '0)
        |=> ((gpi_flags_q & $past(gpi_flags_q)) == $past(gpi_flags_q)))
        else $error("zero write cleared an input flag");

    a_apb_one_wait: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (setup && ce_i) ##1 (apb_req_i.psel && apb_req_i.penable && ce_i)
        |-> apb_rsp_o.pready)
        else $error("access phase not answered at once");

    a_ce_freeze: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        !ce_i |=> ({fan_flags_q, gpi_flags_q}
                   == $past({fan_flags_q, gpi_flags_q})))
        else $error("flags moved while clock enable low");

    a_w1c_fan: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (wr_en && idx == IDX_FAN_FLAGS && wdat[FAN_N-1:0] == '0)
        |=> ((fan_flags_q & $past(fan_flags_q)) == $past(fan_flags_q)))
        else $error("zero or reserved write cleared a fan flag");

endmodule

// file: bench/gfe_apb_host.sv
/*
 * gfe_apb_host: software side of the register port, an APB master
 * doing one transfer at a time plus a write-one-to-clear helper.
 * Assumes the bench calls its tasks from one process only.
 */
`timescale 1ns/1ns
module gfe_apb_host
    import gfe_pkg::*;
(
    // clock
    input  wire logic         core_clk_i,
    // register bus
    input  wire gfe_apb_rsp_t apb_rsp_i,
    output gfe_apb_req_t      apb_req_o
);
    initial apb_req_o = '0;

    ////////////////////////////////////////////////////////////////////////
    // request held until pready is sampled high at an edge
    task automatic xfer(
        input  logic              wr,
        input  logic [ADDR_W-1:0] addr,
        input  logic [31:0]       wdata,
        output logic [31:0]       rdata,
        output logic              err
    );
        @(posedge core_clk_i);
        apb_req_o <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge core_clk_i);
        apb_req_o.penable <= 1'b1;
        do @(posedge core_clk_i); while (apb_rsp_i.pready !== 1'b1);
        rdata = apb_rsp_i.prdata;
        err = apb_rsp_i.pslverr;
        // released lines flip so a stale value never looks valid
        apb_req_o <= '{1'b0, 1'b0, ~wr, ~addr, ~wdata};
    endtask

    ////////////////////////////////////////////////////////////////////////
    // flags go away only through ones written to them
    task automatic clr(input logic [ADDR_W-1:0] addr, input logic [31:0] bits);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, addr, bits, r, e);
    endtask
endmodule

// file: bench/testbench.sv
/*
 * testbench: directed scenarios for the gpi and fan error status bank.
 * Assumes gfe_top and gfe_apb_host; pins idle high, tach counts idle 0.
 */
`timescale 1ns/1ns
module testbench;
    import gfe_pkg::*;
    logic             core_clk  = 1'b0;
    logic             rst_n     = 1'b0;
    logic             ce        = 1'b1;
    logic [GPI_N-1:0] pins      = 8'hff;
    gfe_tach_t        tach      = '0;
    gfe_apb_req_t     req;
    gfe_apb_rsp_t     rsp;
    logic             irq;
    int               err_total = 0;
    int               n_checks  = 0;
    int               cyc       = 0;

    always #2 core_clk = ~core_clk;

    gfe_top dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(ce),
        .apb_req_i(req), .apb_rsp_o(rsp), .gpi_pin_i(pins),
        .tach_count_i(tach), .irq_o(irq));
    gfe_apb_host host (.core_clk_i(core_clk), .apb_rsp_i(rsp),
        .apb_req_o(req));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        logic e;
        host.xfer(1'b0, ba(idx), 32'h0, d, e);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        host.xfer(1'b1, ba(idx), d, r, e);
    endtask

    // low for four edges covers sync plus flag edge, then settle high
    task automatic pin_pulse(input logic [7:0] low);
        pins <= ~low;
        repeat (4) @(posedge core_clk);
        pins <= 8'hff;
        repeat (3) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] d;
        rd(IDX_GPI_FLAGS, d);
        chk("gpi flags reset", d, 32'h0);
        rd(IDX_FAN_FLAGS, d);
        chk("fan flags reset", d, 32'h0);
        rd(IDX_TACH_LIM0, d);
        chk("tach limit reset", d, {16'h0, RST_TACH_LIM});
        chk("irq reset", {31'h0, irq}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_gpi;
        logic [31:0] d;
        for (int k = 0; k < GPI_N; k++)
        begin
            pin_pulse(8'h01 << k);
            rd(IDX_GPI_FLAGS, d);
            chk("gpi flag set", d, 32'h1 << k);
            wr(IDX_GPI_FLAGS, ~(32'h1 << k));
            rd(IDX_GPI_FLAGS, d);
            chk("gpi zero write", d, 32'h1 << k);
            host.clr(ba(IDX_GPI_FLAGS), 32'h1 << k);
            rd(IDX_GPI_FLAGS, d);
            chk("gpi cleared", d, 32'h0);
        end
        // clear while the pin is still low must not win
        pins <= 8'hf7;
        repeat (4) @(posedge core_clk);
        host.clr(ba(IDX_GPI_FLAGS), 32'h8);
        rd(IDX_GPI_FLAGS, d);
        chk("gpi set beats clear", d, 32'h8);
        pins <= 8'hff;
        repeat (3) @(posedge core_clk);
        host.clr(ba(IDX_GPI_FLAGS), 32'hff);
        wr(IDX_GPI_MASK, 32'haa);
        pin_pulse(8'hff);
        rd(IDX_GPI_FLAGS, d);
        chk("gpi masked pins", d, 32'h55);
        wr(IDX_GPI_MASK, 32'h0);
        host.clr(ba(IDX_GPI_FLAGS), 32'hff);
        $display("test gpi done");
    endtask

    task automatic t_fan;
        logic [31:0] d;
        logic [7:0]  idx;
        for (int k = 0; k < FAN_N; k++)
        begin
            idx = IDX_TACH_LIM0 + 8'(k);
            wr(idx, 32'h0100);
            tach[k] <= 16'h0100;
            repeat (3) @(posedge core_clk);
            rd(IDX_FAN_FLAGS, d);
            chk("fan equal limit", d, 32'h0);
            tach[k] <= 16'h0101;
            repeat (3) @(posedge core_clk);
            tach[k] <= 16'h0;
            repeat (2) @(posedge core_clk);
            rd(IDX_FAN_FLAGS, d);
            chk("fan over limit", d, 32'h1 << k);
            wr(IDX_FAN_FLAGS, 32'hffff_fff0);
            rd(IDX_FAN_FLAGS, d);
            chk("fan reserved write", d, 32'h1 << k);
            host.clr(ba(IDX_FAN_FLAGS), 32'h1 << k);
            rd(IDX_FAN_FLAGS, d);
            chk("fan cleared", d, 32'h0);
        end
        $display("test fan done");
    endtask

    task automatic t_sleep;
        logic [31:0] d;
        for (int s = 0; s < 2; s++)
        begin
            wr(IDX_SLP_STATE, (s == 0) ? 32'(GFE_S1) : 32'(GFE_S3));
            wr((s == 0) ? IDX_SLP_M_S1 : IDX_SLP_M_S3, 32'h001);
            pin_pulse(8'h03);
            rd(IDX_GPI_FLAGS, d);
            chk("sleep optional", d, 32'h02);
            host.clr(ba(IDX_GPI_FLAGS), 32'hff);
        end
        wr(IDX_SLP_STATE, 32'(GFE_S45));
        wr(IDX_SLP_M_S45, 32'h000);
        pin_pulse(8'h03);
        rd(IDX_GPI_FLAGS, d);
        chk("sleep s45", d, 32'h01);
        host.clr(ba(IDX_GPI_FLAGS), 32'hff);
        wr(IDX_SLP_M_S45, 32'h021);
        pin_pulse(8'h21);
        rd(IDX_GPI_FLAGS, d);
        chk("sleep s45 selected", d, 32'h00);
        wr(IDX_SLP_STATE, 32'(GFE_S0));
        host.clr(ba(IDX_GPI_FLAGS), 32'hff);
        pin_pulse(8'h01);
        rd(IDX_GPI_FLAGS, d);
        chk("sleep s0", d, 32'h01);
        host.clr(ba(IDX_GPI_FLAGS), 32'hff);
        $display("test sleep done");
    endtask

    task automatic t_irq;
        logic [31:0] d;
        logic        e;
        wr(IDX_IRQ_MASK, 32'h101);
        pin_pulse(8'h02);
        chk("irq masked", {31'h0, irq}, 32'h0);
        pin_pulse(8'h01);
        chk("irq raised", {31'h0, irq}, 32'h1);
        host.clr(ba(IDX_GPI_FLAGS), 32'hff);
        @(negedge core_clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        tach[0] <= 16'h0200;
        repeat (3) @(posedge core_clk);
        tach[0] <= 16'h0;
        @(negedge core_clk);
        chk("irq fan", {31'h0, irq}, 32'h1);
        host.clr(ba(IDX_FAN_FLAGS), 32'hf);
        host.xfer(1'b0, ba(8'h50), 32'h0, d, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        chk("unmapped data", d, 32'h0);
        $display("test irq done");
    endtask

    task automatic t_ce_rst;
        logic [31:0] d;
        // a pin low only while frozen must leave no trace
        ce   <= 1'b0;
        pins <= 8'hfe;
        repeat (6) @(posedge core_clk);
        ce   <= 1'b1;
        pins <= 8'hff;
        repeat (4) @(posedge core_clk);
        rd(IDX_GPI_FLAGS, d);
        chk("ce low freezes", d, 32'h0);
        // state left behind must not survive a mid-run reset
        pin_pulse(8'h01);
        wr(IDX_GPI_MASK, 32'h0f);
        wr(IDX_TACH_LIM0, 32'h0010);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(IDX_GPI_FLAGS, d);
        chk("gpi flags after reset", d, 32'h0);
        rd(IDX_GPI_MASK, d);
        chk("gpi mask after reset", d, {24'h0, RST_GPI_MASK});
        rd(IDX_TACH_LIM0, d);
        chk("tach limit after reset", d, {16'h0, RST_TACH_LIM});
        chk("irq after reset", {31'h0, irq}, 32'h0);
        $display("test ce and reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end

    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_gpi();
        t_fan();
        t_sleep();
        t_irq();
        t_ce_rst();
        summarize();
    end
endmodule
